//--- common/ssx_pkg.sv
package ssx_pkg;
    // data path width
    localparam int DATA_W = 8;
    // file register address width, addresses 0..127
    localparam int ADDR_W = 7;
    localparam logic [6:0] FILE_ADDR_MAX = 7'h7f;
    // destination select encoding
    localparam logic DEST_WORKING = 1'b0;
    localparam logic DEST_FILE = 1'b1;
    // direction-load operand codes
    localparam logic [6:0] DIR_SEL_A = 7'h05;
    localparam logic [6:0] DIR_SEL_B = 7'h06;
    localparam logic [6:0] DIR_SEL_C = 7'h07;
    // reset values
    localparam logic [7:0] WORKING_RESET = 8'h00;
    localparam logic [7:0] DIR_RESET = 8'hff;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic FLAG_RESET = 1'b0;
    // apb register byte offsets
    localparam logic [7:0] OFS_CMD = 8'h00;
    localparam logic [7:0] OFS_OPERAND = 8'h04;
    localparam logic [7:0] OFS_WORKING = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0c;
    localparam logic [7:0] OFS_DIR_A = 8'h10;
    localparam logic [7:0] OFS_DIR_B = 8'h14;
    localparam logic [7:0] OFS_DIR_C = 8'h18;
    localparam logic [7:0] OFS_FILE_RES = 8'h1c;
    // cmd and status register fields
    localparam int CMD_GO_BIT = 8;
    localparam int CMD_DEST_BIT = 7;
    localparam int STAT_C_BIT = 0;
    localparam int STAT_DC_BIT = 1;
    localparam int STAT_Z_BIT = 2;
    localparam int STAT_WB_BIT = 3;

    // instruction selector
    typedef enum logic [2:0] {
        SSX_NOP,
        SSX_SUBTRACT_WORKING_FROM_FILE,
        SSX_SUBTRACT_WORKING_FROM_FILE_BORROW,
        SSX_SWAP_FILE_NIBBLES,
        SSX_XOR_LITERAL_INTO_WORKING,
        SSX_XOR_WORKING_WITH_FILE,
        SSX_LOAD_DIRECTION_FROM_WORKING
    } ssx_op_e;

    // status flags
    typedef struct packed {
        logic zero_flag;
        logic digit_carry_flag;
        logic carry_flag;
    } ssx_flags_s;

    // write-back to the file register
    typedef struct packed {
        logic valid;
        logic [6:0] addr;
        logic [7:0] data;
    } ssx_file_wb_s;
endpackage

//--- sim/ssx_alu_properties.sv
`timescale 1ns/1ps
// protocol watch on the register port of the slice
module ssx_alu_properties
    import ssx_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // first access cycle, the one the slave takes
    sequence access_taken;
        psel && penable && !pready;
    endsequence
    // taken read of the command word
    sequence cmd_read;
        access_taken ##0 (!pwrite && paddr == OFS_CMD);
    endsequence
    chk_ready_one_late: assert property (access_taken |=> pready) else $error("pready not one cycle late");
    chk_ready_single: assert property (pready |=> !pready) else $error("pready longer than a cycle");
    chk_ready_in_access: assert property (pready |-> psel && penable) else $error("pready outside access");
    chk_ready_has_cause: assert property (pready |-> $past(psel && penable && !pready))
        else $error("pready without request");
    chk_rdata_idle: assert property (!pready |-> prdata == 32'h0) else $error("read data outside answer");
    chk_err_with_ready: assert property (pslverr |-> pready) else $error("error without pready");
    chk_err_unmapped: assert property (access_taken ##0 paddr > OFS_FILE_RES |=> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    chk_go_reads_zero: assert property (cmd_read |=> !prdata[CMD_GO_BIT] && !pslverr) else $error("go bit read high");
endmodule

bind ssx_alu_slice ssx_alu_properties u_props (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));

//--- sim/ssx_apb_master.sv
`timescale 1ns/1ps
// core side stand-in: issues register transfers, one at a time
module ssx_apb_master (
    input wire logic pclk,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    output logic psel = 1'b0,
    output logic penable = 1'b0,
    output logic pwrite = 1'b0,
    output logic [7:0] paddr = 8'h00,
    output logic [31:0] pwdata = 32'h0,
    output logic [3:0] pstrb = 4'hf
);
    // called just after a rising edge; psel stays up so a setup may follow at once
    task automatic access(input logic wr, input logic [7:0] a, input logic [31:0] d,
                          output logic [31:0] q, output logic err, output logic ok);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // bounded wait, a hung slave must not stall the run
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        q = prdata;
        err = pslverr;
        ok = (pready === 1'b1);
        // access phase ends here; a held penable would be taken again
        penable <= 1'b0;
    endtask
endmodule

//--- sim/sub_swap_xor_alu_slice_bench.sv
`timescale 1ns/1ps
module sub_swap_xor_alu_slice_bench;
    import ssx_pkg::*;
    localparam ssx_op_e SUB = SSX_SUBTRACT_WORKING_FROM_FILE;
    localparam ssx_op_e SUBB = SSX_SUBTRACT_WORKING_FROM_FILE_BORROW;
    localparam ssx_op_e XORF = SSX_XOR_WORKING_WITH_FILE;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdata;
    logic [3:0] pstrb;
    // expected state: working, flags, last write-back, directions
    logic [7:0] w = 8'h00, res = 8'h00;
    logic c = 1'b0, dc = 1'b0, z = 1'b0, wb = 1'b0;
    logic [6:0] ea = 7'h00;
    logic [7:0] dr [3] = '{8'hff, 8'hff, 8'hff};
    int failures = 0, check_count = 0;
    always #12.5 pclk = ~pclk;
    ssx_alu_slice dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    ssx_apb_master m (.pclk(pclk), .prdata(prdata), .pready(pready), .pslverr(pslverr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb));
    task automatic complete_run();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // a hung transfer ends the run
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
        logic ok;
        m.access(wr, a, d, rdata, err, ok);
        if (!ok) begin
            failures++;
            complete_run();
        end
    endtask
    // reads back the results the last step could have touched: working, status, file result, directions
    task automatic verify();
        xfer(0, OFS_WORKING, 0);
        check(rdata, {24'h0, w});
        xfer(0, OFS_STATUS, 0);
        check(rdata, {28'h0, wb, z, dc, c});
        if (wb) xfer(0, OFS_FILE_RES, 0);
        if (wb) check(rdata, {17'h0, ea, res});
        for (int i = 0; i < 3; i++) begin
            xfer(0, OFS_DIR_A + 8'(4 * i), 0);
            check(rdata, {24'h0, dr[i]});
        end
    endtask
    // op, dest and address are set first, then the same word with go
    task automatic run(input ssx_op_e op, input logic d, input logic [6:0] a, input logic [7:0] f, input logic [7:0] k);
        logic b;
        logic [8:0] r;
        logic [4:0] n;
        logic [7:0] y;
        y = 8'h00;
        b = (op == SUBB) ? !c : 1'b0;
        r = {1'b0, f} - {1'b0, w} - 9'(b);
        n = {1'b0, f[3:0]} - {1'b0, w[3:0]} - 5'(b);
        xfer(1, OFS_OPERAND, {16'h0, k, f});
        xfer(1, OFS_CMD, {20'h0, op, 1'b0, d, a});
        xfer(1, OFS_CMD, {20'h0, op, 1'b1, d, a});
        case (op)
            SUB, SUBB: {y, c, dc} = {r[7:0], !r[8], !n[4]};
            SSX_SWAP_FILE_NIBBLES: y = {f[3:0], f[7:4]};
            SSX_XOR_LITERAL_INTO_WORKING: y = w ^ k;
            XORF: y = w ^ f;
            default: if (k inside {[8'h05:8'h07]}) dr[k - 8'h05] = w;
        endcase
        if (op inside {SUB, SUBB, XORF, SSX_XOR_LITERAL_INTO_WORKING}) z = (y == 8'h00);
        // xor literal and direction load leave the write-back record as it was
        if (op == SSX_XOR_LITERAL_INTO_WORKING) begin
            w = y;
        end else if (op != SSX_LOAD_DIRECTION_FROM_WORKING) begin
            wb = d;
            if (d) {ea, res} = {a, y};
            else w = y;
        end
        verify();
    endtask
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        verify();
        $display("reset test done");
        xfer(1, OFS_WORKING, 32'h3c);
        w = 8'h3c;
        run(SUB, 1, 7'h7f, 8'h20, 0);
        run(SUBB, 0, 7'h11, 8'h3d, 0);
        xfer(1, OFS_WORKING, 32'h01);
        w = 8'h01;
        run(SUBB, 0, 7'h12, 8'h01, 0);
        $display("subtract test done");
        xfer(1, OFS_STATUS, 32'h5);
        {z, dc, c} = 3'b101;
        run(SSX_SWAP_FILE_NIBBLES, 0, 7'h41, 8'h0f, 0);
        // file write just before xor literal: its record must survive
        run(SSX_SWAP_FILE_NIBBLES, 1, 7'h40, 8'ha5, 0);
        run(SSX_XOR_LITERAL_INTO_WORKING, 1, 7'h05, 0, 8'hf0);
        run(XORF, 1, 7'h22, 8'h5a, 0);
        run(XORF, 0, 7'h23, 8'h00, 0);
        $display("swap and xor test done");
        for (int k = 4; k < 9; k++) begin
            xfer(1, OFS_WORKING, 32'(8'h10 + k));
            w = 8'(8'h10 + k);
            run(SSX_LOAD_DIRECTION_FROM_WORKING, 0, 0, 0, 8'(k));
        end
        // top operand bit set: no direction register may load
        run(SSX_LOAD_DIRECTION_FROM_WORKING, 0, 0, 0, 8'h85);
        xfer(1, OFS_DIR_A, 32'h0);
        xfer(0, OFS_DIR_A, 0);
        check(rdata, {24'h0, dr[0]});
        xfer(0, 8'h20, 0); check({31'h0, err}, 32'h1);
        xfer(0, OFS_CMD, 0); check({31'h0, rdata[CMD_GO_BIT]}, 32'h0);
        $display("direction and refusal test done");
        complete_run();
    end
endmodule

//--- src/ssx_alu_slice.sv
`timescale 1ns/1ps
// Notes on behaviour
// - subtract: file minus working, carry means no borrow
// - dest bit 0 to working, 1 to file
// - borrow subtract also takes inverted carry off
// - swap exchanges nibbles, flags untouched
// - xor literal into working, zero only
// - operand 5/6/7 loads direction a/b/c
// - xor file with working, zero only
module ssx_alu_slice
    import ssx_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    // software-visible state
    ssx_op_e op_sel;                 // operation picked by cmd write
    logic dest_sel;                  // destination select bit
    logic [6:0] file_addr;           // addressed file register
    logic [7:0] file_value;          // operand from file register
    logic [7:0] literal;             // literal or direction operand
    logic [7:0] working;             // working register
    ssx_flags_s flags;               // carry, digit carry, zero
    logic [7:0] port_a_direction;    // direction latches
    logic [7:0] port_b_direction;
    logic [7:0] port_c_direction;
    ssx_file_wb_s file_wb;           // last file write-back
    logic [31:0] rdata;
    logic ready;
    logic slverr;

    // next values
    ssx_op_e next_op_sel;
    logic next_dest_sel;
    logic [6:0] next_file_addr;
    logic [7:0] next_file_value;
    logic [7:0] next_literal;
    logic [7:0] next_working;
    ssx_flags_s next_flags;
    logic [7:0] next_port_a_direction;
    logic [7:0] next_port_b_direction;
    logic [7:0] next_port_c_direction;
    ssx_file_wb_s next_file_wb;
    logic [31:0] next_rdata;
    logic next_ready;
    logic next_slverr;

    // execution strobe from a cmd write with go set
    logic exec;

    // decode is shared by read and write paths
    function automatic logic is_mapped(input logic [7:0] a);
        case (a)
            OFS_CMD, OFS_OPERAND, OFS_WORKING, OFS_STATUS,
            OFS_DIR_A, OFS_DIR_B, OFS_DIR_C, OFS_FILE_RES: is_mapped = 1'b1;
            default: is_mapped = 1'b0;
        endcase
    endfunction

    // apb access phase seen; one wait state keeps pready registered
    logic access;
    assign access = psel && penable && !ready;

    // alu results
    logic [8:0] diff;                // bit 8 set on borrow
    logic [4:0] ndiff;               // nibble difference
    logic borrow_in;
    logic [7:0] result;
    logic upd_cz;                    // carry/digit carry updated
    logic upd_z;                     // zero updated

    // datapath: compute result and which flags move
    always_comb begin
        borrow_in = 1'b0;
        if (op_sel == SSX_SUBTRACT_WORKING_FROM_FILE_BORROW) begin
            borrow_in = ~flags.carry_flag;
        end
        // file minus working minus borrow, two's complement
        diff = {1'b0, file_value} - {1'b0, working} - {8'h00, borrow_in};
        ndiff = {1'b0, file_value[3:0]} - {1'b0, working[3:0]} - {4'h0, borrow_in};
        result = 8'h00;
        upd_cz = 1'b0;
        upd_z = 1'b0;
        case (op_sel)
            SSX_SUBTRACT_WORKING_FROM_FILE, SSX_SUBTRACT_WORKING_FROM_FILE_BORROW: begin
                result = diff[7:0];
                upd_cz = 1'b1;
                upd_z = 1'b1;
            end
            SSX_SWAP_FILE_NIBBLES: begin
                result = {file_value[3:0], file_value[7:4]};
            end
            SSX_XOR_LITERAL_INTO_WORKING: begin
                result = working ^ literal;
                upd_z = 1'b1;
            end
            SSX_XOR_WORKING_WITH_FILE: begin
                result = working ^ file_value;
                upd_z = 1'b1;
            end
            default: begin
                result = 8'h00;
            end
        endcase
    end

    // register writes, execution and read data
    always_comb begin
        next_op_sel = op_sel;
        next_dest_sel = dest_sel;
        next_file_addr = file_addr;
        next_file_value = file_value;
        next_literal = literal;
        next_working = working;
        next_flags = flags;
        next_port_a_direction = port_a_direction;
        next_port_b_direction = port_b_direction;
        next_port_c_direction = port_c_direction;
        next_file_wb = file_wb;
        next_rdata = 32'h0000_0000;
        next_ready = access;
        next_slverr = access && !is_mapped(paddr);
        exec = 1'b0;
        // writes land in the wait state; pready follows one cycle on
        if (access && pwrite) begin
            case (paddr)
                OFS_CMD: begin
                    if (pstrb[0]) begin
                        next_file_addr = pwdata[6:0];
                        next_dest_sel = pwdata[CMD_DEST_BIT];
                    end
                    if (pstrb[1]) begin
                        next_op_sel = ssx_op_e'(pwdata[11:9]);
                        exec = pwdata[CMD_GO_BIT];
                    end
                end
                OFS_OPERAND: begin
                    if (pstrb[0]) next_file_value = pwdata[7:0];
                    if (pstrb[1]) next_literal = pwdata[15:8];
                end
                OFS_WORKING: begin
                    if (pstrb[0]) next_working = pwdata[7:0];
                end
                OFS_STATUS: begin
                    if (pstrb[0]) begin
                        next_flags.carry_flag = pwdata[STAT_C_BIT];
                        next_flags.digit_carry_flag = pwdata[STAT_DC_BIT];
                        next_flags.zero_flag = pwdata[STAT_Z_BIT];
                    end
                end
                default: begin
                    next_op_sel = op_sel;
                end
            endcase
        end
        // execute using operands in place before this write
        if (exec) begin
            if (upd_cz) begin
                next_flags.carry_flag = ~diff[8];
                next_flags.digit_carry_flag = ~ndiff[4];
            end
            if (upd_z) begin
                next_flags.zero_flag = (result == 8'h00);
            end
            if (op_sel == SSX_LOAD_DIRECTION_FROM_WORKING) begin
                // flags untouched; unknown operand loads nothing, top bit included
                case (literal)
                    {1'b0, DIR_SEL_A}: next_port_a_direction = working;
                    {1'b0, DIR_SEL_B}: next_port_b_direction = working;
                    {1'b0, DIR_SEL_C}: next_port_c_direction = working;
                    default: next_port_a_direction = port_a_direction;
                endcase
            end else if (op_sel == SSX_XOR_LITERAL_INTO_WORKING) begin
                next_working = result;
            end else if (op_sel != SSX_NOP) begin
                // destination select routes the result
                if (dest_sel == DEST_WORKING) begin
                    next_working = result;
                    next_file_wb.valid = 1'b0;
                end else begin
                    next_file_wb.valid = 1'b1;
                    next_file_wb.addr = file_addr & FILE_ADDR_MAX;
                    next_file_wb.data = result;
                end
            end
        end
        // read mux
        if (access && !pwrite) begin
            case (paddr)
                OFS_CMD: next_rdata = {20'h00000, op_sel, 1'b0, dest_sel, file_addr};
                OFS_OPERAND: next_rdata = {16'h0000, literal, file_value};
                OFS_WORKING: next_rdata = {24'h000000, working};
                OFS_STATUS: next_rdata = {28'h0000000, file_wb.valid, flags.zero_flag,
                                          flags.digit_carry_flag, flags.carry_flag};
                OFS_DIR_A: next_rdata = {24'h000000, port_a_direction};
                OFS_DIR_B: next_rdata = {24'h000000, port_b_direction};
                OFS_DIR_C: next_rdata = {24'h000000, port_c_direction};
                OFS_FILE_RES: next_rdata = {16'h0000, 1'b0, file_wb.addr, file_wb.data};
                default: next_rdata = 32'h0000_0000;
            endcase
        end
    end

    // state registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            op_sel <= SSX_NOP;
            dest_sel <= DEST_WORKING;
            file_addr <= 7'h00;
            file_value <= CTRL_RESET;
            literal <= CTRL_RESET;
            working <= WORKING_RESET;
            flags <= '{FLAG_RESET, FLAG_RESET, FLAG_RESET};
            port_a_direction <= DIR_RESET;
            port_b_direction <= DIR_RESET;
            port_c_direction <= DIR_RESET;
            file_wb <= '0;
            rdata <= 32'h0000_0000;
            ready <= 1'b0;
            slverr <= 1'b0;
        end else begin
            op_sel <= next_op_sel;
            dest_sel <= next_dest_sel;
            file_addr <= next_file_addr;
            file_value <= next_file_value;
            literal <= next_literal;
            working <= next_working;
            flags <= next_flags;
            port_a_direction <= next_port_a_direction;
            port_b_direction <= next_port_b_direction;
            port_c_direction <= next_port_c_direction;
            file_wb <= next_file_wb;
            rdata <= next_rdata;
            ready <= next_ready;
            slverr <= next_slverr;
        end
    end

    // outputs straight from flops
    assign prdata = rdata;
    assign pready = ready;
    assign pslverr = slverr;
endmodule
